// ===== verilog/pocr_pkg.sv
// Package: field layout, codes and types of the pixel operation command register
`default_nettype none
package pocr_pkg;
  localparam logic [6:0] POCR_DEST_Y_OFS  = 7'h7A;
  localparam logic [6:0] POCR_CMD_OFS     = 7'h7C;
  localparam logic [15:0] POCR_DEST_Y_RST = 16'h0000;
  localparam logic [31:0] POCR_CMD_RST    = 32'h00000000;
  localparam int POCR_BG_POS   = 30;
  localparam int POCR_FG_POS   = 28;
  localparam int POCR_STEP_POS = 24;
  localparam int POCR_SRC_POS  = 20;
  localparam int POCR_DST_POS  = 16;
  localparam int POCR_PAT_POS  = 12;
  localparam int POCR_MSK_POS  = 6;
  localparam int POCR_DM_POS   = 4;
  localparam int POCR_DX_POS   = 2;
  localparam int POCR_DY_POS   = 1;
  localparam int POCR_DZ_POS   = 0;
  localparam logic [31:0] POCR_UNUSED_MASK = 32'h00000F08;
  localparam logic [1:0] POCR_SRC_COLOR = 2'h0;
  localparam logic [1:0] POCR_SRC_MAP   = 2'h2;
  localparam logic [3:0] POCR_STEP_DSR  = 4'h2;
  localparam logic [3:0] POCR_STEP_LDR  = 4'h3;
  localparam logic [3:0] POCR_STEP_DSW  = 4'h4;
  localparam logic [3:0] POCR_STEP_LDW  = 4'h5;
  localparam logic [3:0] POCR_STEP_BLT  = 4'h8;
  localparam logic [3:0] POCR_STEP_IBLT = 4'h9;
  localparam logic [3:0] POCR_STEP_FILL = 4'hA;
  localparam logic [3:0] POCR_MAP_A     = 4'h1;
  localparam logic [3:0] POCR_MAP_C     = 4'h3;
  localparam logic [3:0] POCR_PAT_FIXED = 4'h8;
  localparam logic [3:0] POCR_PAT_SRC   = 4'h9;
  localparam logic [1:0] POCR_MSK_RSVD  = 2'h3;

  typedef enum logic [2:0] {
    POCR_OP_NONE, POCR_OP_STEP_READ, POCR_OP_LINE_READ, POCR_OP_STEP_WRITE,
    POCR_OP_LINE_WRITE, POCR_OP_BLOCK, POCR_OP_INV_BLOCK, POCR_OP_FILL_BLOCK
  } pocr_op_e;

  typedef enum logic {POCR_IDLE, POCR_RUN} pocr_state_e;

  typedef struct packed {
    pocr_op_e   op_kind;
    logic [1:0] background_source_select;
    logic [1:0] foreground_source_select;
    logic [3:0] src_map;
    logic [3:0] dst_map;
    logic [3:0] pat_map;
    logic       pattern_fixed_fg;
    logic       pattern_from_src;
    logic [1:0] clip_map_mode;
    logic [1:0] drawing_mode_field;
    logic       horizontal_direction_flag;
    logic       vertical_direction_flag;
    logic       major_axis_flag;
    logic       reserved_code;
  } pocr_fields_s;
endpackage
`default_nettype wire

// ===== verilog/pocr_core.sv
// Pixel operation command register and destination Y coordinate register
// Operation
// - Destination Y register holds the 16-bit destination pixel row coordinate.
// - Command contents stay frozen while an operation runs.
// - Command bytes sit on mirrored lanes when big-endian ordering is selected.
// - Writing command byte 3 starts every operation except draw-and-step.
// - Draw-and-step starts only on a direction steps register write.
// - Byte 3 bits 7:6 pick background colour or source map.
// - Byte 3 bits 5:4 pick foreground colour or source map.
// - Byte 3 bits 3:0 decode the step function; other codes reserved.
// - Byte 2 bits 7:4 select source map A, B or C.
// - Byte 2 bits 3:0 select destination map A, B or C.
// - Byte 1 bits 7:4 select pattern map, fixed foreground or source-derived.
// - Fixed foreground pattern forces pattern 1 on every pixel.
// - Source-derived pattern: zero source pixel background, nonzero foreground.
// - Byte 0 bits 7:6 decode the mask map mode.
// - Byte 0 bits 5:4 decode the drawing mode for lines.
// - Byte 0 bits 2:0 hold horizontal, vertical and major-axis flags.
`default_nettype none
module pocr_core
  import pocr_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // Register port
  input  wire logic [4:0]   reg_word_addr,
  input  wire logic         reg_wr_en,
  input  wire logic         reg_rd_en,
  input  wire logic [3:0]   reg_byte_en,
  input  wire logic [31:0]  reg_wr_data,
  output logic      [31:0]  reg_rd_data,
  output logic              reg_rd_valid,
  input  wire logic         big_endian_sel,
  // Coprocessor side
  input  wire logic         dir_steps_wr,
  input  wire logic         op_done,
  input  wire logic         mix_sample,
  input  wire logic         pattern_pel,
  input  wire logic         src_pel_nonzero,
  // Command outputs
  output logic              op_start,
  output logic              op_busy,
  output pocr_fields_s      cmd_fields,
  output logic [15:0]       dest_y,
  output logic              mix_fg,
  output logic              mix_use_src
);

  function automatic pocr_fields_s pocr_decode(input logic [31:0] c);
    pocr_fields_s f;
    logic [3:0] st;
    logic       bad;
    st = c[POCR_STEP_POS +: 4];
    f = '0;
    f.background_source_select = c[POCR_BG_POS +: 2];
    f.foreground_source_select = c[POCR_FG_POS +: 2];
    f.src_map = c[POCR_SRC_POS +: 4];
    f.dst_map = c[POCR_DST_POS +: 4];
    f.pat_map = c[POCR_PAT_POS +: 4];
    f.clip_map_mode = c[POCR_MSK_POS +: 2];
    f.drawing_mode_field = c[POCR_DM_POS +: 2];
    f.horizontal_direction_flag = c[POCR_DX_POS];
    f.vertical_direction_flag = c[POCR_DY_POS];
    f.major_axis_flag = c[POCR_DZ_POS];
    case (st)
      POCR_STEP_DSR:  f.op_kind = POCR_OP_STEP_READ;
      POCR_STEP_LDR:  f.op_kind = POCR_OP_LINE_READ;
      POCR_STEP_DSW:  f.op_kind = POCR_OP_STEP_WRITE;
      POCR_STEP_LDW:  f.op_kind = POCR_OP_LINE_WRITE;
      POCR_STEP_BLT:  f.op_kind = POCR_OP_BLOCK;
      POCR_STEP_IBLT: f.op_kind = POCR_OP_INV_BLOCK;
      POCR_STEP_FILL: f.op_kind = POCR_OP_FILL_BLOCK;
      default:        f.op_kind = POCR_OP_NONE;
    endcase
    f.pattern_fixed_fg = (f.pat_map == POCR_PAT_FIXED);
    f.pattern_from_src = (f.pat_map == POCR_PAT_SRC);
    bad = (f.op_kind == POCR_OP_NONE);
    bad = bad | (f.background_source_select != POCR_SRC_COLOR
                 && f.background_source_select != POCR_SRC_MAP);
    bad = bad | (f.foreground_source_select != POCR_SRC_COLOR
                 && f.foreground_source_select != POCR_SRC_MAP);
    bad = bad | (f.src_map < POCR_MAP_A) | (f.src_map > POCR_MAP_C);
    bad = bad | (f.dst_map < POCR_MAP_A) | (f.dst_map > POCR_MAP_C);
    bad = bad | (((f.pat_map < POCR_MAP_A) | (f.pat_map > POCR_MAP_C))
                 & ~f.pattern_fixed_fg & ~f.pattern_from_src);
    bad = bad | (f.clip_map_mode == POCR_MSK_RSVD);
    // Unused bits are flagged too; software is expected to leave them zero
    bad = bad | (|(c & POCR_UNUSED_MASK));
    f.reserved_code = bad;
    return f;
  endfunction

  // Lane that carries command byte k in the current byte ordering
  function automatic logic [1:0] pocr_lane(input logic [1:0] k, input logic be);
    return be ? 2'(2'h3 - k) : k;
  endfunction

  pocr_state_e  state_reg;
  pocr_state_e  state_next;
  logic [31:0]  cmd_reg;
  logic [31:0]  cmd_next;
  logic [15:0]  dest_y_next;
  pocr_fields_s fields_next;

  wire logic cmd_hit   = reg_wr_en && (reg_word_addr == POCR_CMD_OFS[6:2]);
  wire logic y_hit     = reg_wr_en && (reg_word_addr == POCR_DEST_Y_OFS[6:2]);
  wire logic y_rd_hit  = reg_rd_en && (reg_word_addr == POCR_DEST_Y_OFS[6:2]);
  wire logic idle      = (state_reg == POCR_IDLE);
  // Writes during a running operation are dropped so the datapath sees a stable command
  wire logic cmd_wr_ok = cmd_hit && idle;
  wire logic [1:0] top_lane = pocr_lane(2'h3, big_endian_sel);
  wire logic top_written = cmd_wr_ok && reg_byte_en[top_lane];
  wire logic y_lo_lane   = big_endian_sel;
  wire logic [1:0] y_lo  = {1'b1, y_lo_lane};
  wire logic [1:0] y_hi  = {1'b1, ~y_lo_lane};

  always_comb begin
    cmd_next = cmd_reg;
    for (int k = 0; k < 4; k++) begin
      if (cmd_wr_ok && reg_byte_en[pocr_lane(2'(k), big_endian_sel)]) begin
        cmd_next[8*k +: 8] = reg_wr_data[8*pocr_lane(2'(k), big_endian_sel) +: 8];
      end
    end
  end

  always_comb begin
    dest_y_next = dest_y;
    if (y_hit && reg_byte_en[y_lo]) begin
      dest_y_next[7:0] = reg_wr_data[8*y_lo +: 8];
    end
    if (y_hit && reg_byte_en[y_hi]) begin
      dest_y_next[15:8] = reg_wr_data[8*y_hi +: 8];
    end
  end

  assign fields_next = pocr_decode(cmd_next);

  wire logic is_step_op = (fields_next.op_kind == POCR_OP_STEP_READ)
                        || (fields_next.op_kind == POCR_OP_STEP_WRITE);
  wire logic held_step  = (cmd_fields.op_kind == POCR_OP_STEP_READ)
                        || (cmd_fields.op_kind == POCR_OP_STEP_WRITE);
  // A reserved step code never starts anything
  wire logic start_cmd  = top_written && !is_step_op
                        && (fields_next.op_kind != POCR_OP_NONE);
  wire logic start_step = dir_steps_wr && idle && !cmd_wr_ok && held_step;
  wire logic start_any  = start_cmd || start_step;

  always_comb begin
    case (state_reg)
      POCR_IDLE: state_next = start_any ? POCR_RUN : POCR_IDLE;
      POCR_RUN:  state_next = op_done ? POCR_IDLE : POCR_RUN;
      default:   state_next = POCR_IDLE;
    endcase
  end

  // Pattern 1 selects the foreground mix
  wire logic pat_eff = cmd_fields.pattern_fixed_fg ? 1'b1
                     : cmd_fields.pattern_from_src ? src_pel_nonzero
                     : pattern_pel;
  wire logic [1:0] mix_src_code = pat_eff ? cmd_fields.foreground_source_select
                                          : cmd_fields.background_source_select;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= POCR_IDLE;
      cmd_reg   <= POCR_CMD_RST;
      cmd_fields <= pocr_decode(POCR_CMD_RST);
      dest_y    <= POCR_DEST_Y_RST;
      op_start  <= 1'b0;
      op_busy   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cmd_reg    <= cmd_next;
      cmd_fields <= fields_next;
      dest_y     <= dest_y_next;
      op_start   <= start_any;
      op_busy    <= (state_next == POCR_RUN);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mix_fg      <= 1'b0;
      mix_use_src <= 1'b0;
    end else if (mix_sample) begin
      mix_fg      <= pat_eff;
      mix_use_src <= (mix_src_code == POCR_SRC_MAP);
    end
  end

  // Only the Y register reads back; the command register is write-only and reads zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rd_data  <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      reg_rd_data  <= '0;
      if (y_rd_hit) begin
        reg_rd_data[8*y_lo +: 8] <= dest_y[7:0];
        reg_rd_data[8*y_hi +: 8] <= dest_y[15:8];
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  cmd_frozen_a: assert property (op_busy && !op_done |=> $stable(cmd_fields))
    else $error("command changed while busy");
  start_busy_a: assert property (op_start |-> op_busy)
    else $error("start without busy");
  top_start_a: assert property (idle && cmd_hit && reg_byte_en[top_lane]
      && reg_wr_data[8*top_lane +: 4] == POCR_STEP_BLT |=> op_start)
    else $error("block transfer did not start");
  low_no_start_a: assert property (cmd_hit && !reg_byte_en[top_lane] && !dir_steps_wr
      |=> !op_start)
    else $error("start without top byte");
  step_hold_a: assert property (idle && cmd_hit && reg_byte_en[top_lane]
      && reg_wr_data[8*top_lane +: 4] == POCR_STEP_DSW |=> !op_start)
    else $error("draw and step started by command write");
  step_go_a: assert property (idle && !cmd_hit && dir_steps_wr && held_step
      |=> op_start ##1 !op_start)
    else $error("draw and step did not start once");
  fixed_pat_a: assert property (mix_sample && cmd_fields.pattern_fixed_fg |=> mix_fg)
    else $error("fixed pattern gave background");
  src_pat_a: assert property (mix_sample && cmd_fields.pattern_from_src
      |=> mix_fg == $past(src_pel_nonzero))
    else $error("source pattern wrong");
  y_write_a: assert property (y_hit && reg_byte_en[y_lo] && reg_byte_en[y_hi]
      |=> dest_y == {$past(reg_wr_data[8*y_hi +: 8]), $past(reg_wr_data[8*y_lo +: 8])})
    else $error("destination y not stored");
  octant_a: assert property (op_start |-> cmd_fields.horizontal_direction_flag
      == cmd_reg[POCR_DX_POS] && cmd_fields.major_axis_flag == cmd_reg[POCR_DZ_POS])
    else $error("octant flags mismatch");
  dir_flag_a: assert property (op_start
      |-> cmd_fields.vertical_direction_flag == cmd_reg[POCR_DY_POS])
    else $error("vertical flag mismatch");
  done_idle_a: assert property (op_busy && op_done |=> !op_busy)
    else $error("busy after done");
  busy_drop_a: assert property (!idle |=> !op_start)
    else $error("start while running");

  rd_valid_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read valid missing");
  y_read_le_a: assert property (y_rd_hit && !big_endian_sel
      |=> reg_rd_data[31:16] == $past(dest_y))
    else $error("destination y read wrong");
  y_read_be_a: assert property (y_rd_hit && big_endian_sel
      |=> reg_rd_data[31:16] == {$past(dest_y[7:0]), $past(dest_y[15:8])})
    else $error("swapped destination y read wrong");
  cmd_rd_zero_a: assert property (reg_rd_en && !y_rd_hit |=> reg_rd_data == 32'h00000000)
    else $error("write-only register read nonzero");
  y_keep_a: assert property (!y_hit |=> $stable(dest_y))
    else $error("destination y changed without write");

  le_lane_a: assert property (cmd_wr_ok && !big_endian_sel && reg_byte_en[3]
      |=> cmd_reg[31:24] == $past(reg_wr_data[31:24]))
    else $error("top command byte on wrong lane");
  be_lane_a: assert property (cmd_wr_ok && big_endian_sel && reg_byte_en[0]
      |=> cmd_reg[31:24] == $past(reg_wr_data[7:0]))
    else $error("swapped top command byte on wrong lane");
  rsvd_step_a: assert property (cmd_hit && fields_next.op_kind == POCR_OP_NONE
      && !dir_steps_wr |=> !op_start)
    else $error("reserved step code started");
  clip_rsvd_a: assert property (cmd_fields.clip_map_mode == POCR_MSK_RSVD
      |-> cmd_fields.reserved_code)
    else $error("reserved mask mode not flagged");
  unused_rsvd_a: assert property (|(cmd_reg & POCR_UNUSED_MASK)
      |-> cmd_fields.reserved_code)
    else $error("nonzero unused bits not flagged");
  dm_field_a: assert property (op_start
      |-> cmd_fields.drawing_mode_field == cmd_reg[POCR_DM_POS +: 2])
    else $error("drawing mode mismatch");
  map_field_a: assert property (op_start
      |-> {cmd_fields.src_map, cmd_fields.dst_map} == cmd_reg[POCR_DST_POS +: 8])
    else $error("map selects mismatch");
  src_field_a: assert property (op_start
      |-> {cmd_fields.background_source_select, cmd_fields.foreground_source_select}
          == cmd_reg[POCR_FG_POS +: 4])
    else $error("source selects mismatch");

  mix_hold_a: assert property (!mix_sample |=> $stable(mix_fg) && $stable(mix_use_src))
    else $error("mix changed without sample");
  pat_map_a: assert property (mix_sample && !cmd_fields.pattern_fixed_fg
      && !cmd_fields.pattern_from_src |=> mix_fg == $past(pattern_pel))
    else $error("map pattern wrong");
  fg_src_a: assert property (mix_sample && pat_eff
      |=> mix_use_src == ($past(cmd_fields.foreground_source_select) == POCR_SRC_MAP))
    else $error("foreground source wrong");
  bg_src_a: assert property (mix_sample && !pat_eff
      |=> mix_use_src == ($past(cmd_fields.background_source_select) == POCR_SRC_MAP))
    else $error("background source wrong");


  blt_cov: cover property (op_start && cmd_fields.op_kind == POCR_OP_BLOCK);
  step_cov: cover property (op_start && cmd_fields.op_kind == POCR_OP_STEP_WRITE);
  be_cov: cover property (big_endian_sel && op_start);
  busy_wr_cov: cover property (op_busy && cmd_hit);
  src_pat_cov: cover property (mix_sample && cmd_fields.pattern_from_src);
endmodule
`default_nettype wire

// ===== tb/pocr_dp_model.sv
// Datapath stand-in: answers each operation start with a done pulse
`default_nettype none
module pocr_dp_model
  import pocr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Start and done handshake
  input  wire logic       op_start,
  input  wire logic [7:0] lat,
  output logic            op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  logic       run_reg;
  // Delay is set live by the bench so both prompt and slow answers occur
  always_ff @(posedge core_clk) begin
    op_done <= 1'b0;
    if (srst) begin
      run_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (op_start) begin
      run_reg <= 1'b1;
      cnt_reg <= lat;
    end else if (run_reg && cnt_reg == 8'h00) begin
      run_reg <= 1'b0;
      op_done <= 1'b1;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Testbench: register accesses and command decode checks
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pocr_pkg::*;
  localparam logic [3:0] PATS [5] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
  logic         core_clk, srst, wr, rd, bes, dsw, mix, ppel, spel;
  logic         rvalid, op_start, op_busy, op_done, mix_fg, mix_use_src;
  logic [4:0]   addr;
  logic [3:0]   be;
  logic [31:0]  wd, rdata, w;
  logic [15:0]  dy;
  logic [7:0]   lat;
  pocr_fields_s f;
  int           error_cnt, samples_checked, cyc;

  pocr_core dut_u (.core_clk(core_clk), .srst(srst), .reg_word_addr(addr), .reg_wr_en(wr),
    .reg_rd_en(rd), .reg_byte_en(be), .reg_wr_data(wd), .reg_rd_data(rdata),
    .reg_rd_valid(rvalid), .big_endian_sel(bes), .dir_steps_wr(dsw), .op_done(op_done),
    .mix_sample(mix), .pattern_pel(ppel), .src_pel_nonzero(spel), .op_start(op_start),
    .op_busy(op_busy), .cmd_fields(f), .dest_y(dy), .mix_fg(mix_fg),
    .mix_use_src(mix_use_src));
  pocr_dp_model dp_u (.core_clk(core_clk), .srst(srst), .op_start(op_start), .lat(lat),
    .op_done(op_done));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrt(input logic [4:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    be <= b;
    wd <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rdt(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk("rd_valid", rvalid, 1);
    chk("rd_data", rdata & m, exp);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 200 && op_busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("op_busy", op_busy, 0);
  endtask

  // Unused bits are always written as zero
  function automatic logic [31:0] cmdw(input logic [1:0] bg, fg, input logic [3:0] st, sm,
    dm, pt, input logic [1:0] mk, md, input logic [2:0] oc);
    return {bg, fg, st, sm, dm, pt, 4'h0, mk, md, 1'b0, oc};
  endfunction

  function automatic pocr_op_e kind(input logic [3:0] st);
    case (st)
      4'h2: return POCR_OP_STEP_READ;
      4'h3: return POCR_OP_LINE_READ;
      4'h4: return POCR_OP_STEP_WRITE;
      4'h5: return POCR_OP_LINE_WRITE;
      4'h8: return POCR_OP_BLOCK;
      4'h9: return POCR_OP_INV_BLOCK;
      4'hA: return POCR_OP_FILL_BLOCK;
      default: return POCR_OP_NONE;
    endcase
  endfunction

  initial begin
    logic [3:0] st, pt;
    logic [1:0] bg, fg;
    logic       go, efg;
    pocr_op_e   k;
    int         ln;
    {srst, wr, rd, bes, dsw, mix, ppel, spel} = 8'hFF << 7;
    {addr, be, wd, lat} = '0;
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk("rst", {op_busy, op_start, dy, f.op_kind, f.reserved_code}, 32'h00000001);
    wrt(5'h1E, 4'hC, 32'hF8000000);
    chk("dest_y", dy, 32'h0000F800);
    rdt(5'h1E, 32'hFFFF0000, 32'hF8000000);
    bes <= 1'b1;
    wrt(5'h1E, 4'hC, 32'hFF170000);
    chk("dest_y_be", dy, 32'h000017FF);
    bes <= 1'b0;
    rdt(5'h00, 32'hFFFFFFFF, 32'h00000000);
    rdt(5'h1F, 32'hFFFFFFFF, 32'h00000000);
    for (int s = 0; s < 16; s++) begin
      st = 4'(s);
      pt = PATS[s % 5];
      bg = {st[0], 1'b0};
      fg = {st[1], 1'b0};
      k = kind(st);
      go = k inside {POCR_OP_LINE_READ, POCR_OP_LINE_WRITE, POCR_OP_BLOCK,
        POCR_OP_INV_BLOCK, POCR_OP_FILL_BLOCK};
      w = cmdw(bg, fg, st, 4'(s % 3 + 1), 4'(3 - s % 3), pt, st[1:0], st[3:2], st[2:0]);
      lat <= 8'(s);
      wrt(5'h1F, 4'hF, w);
      chk("op_start", op_start, go);
      chk("op_kind", f.op_kind, k);
      chk("maps", {f.src_map, f.dst_map, f.pat_map}, w[23:12]);
      chk("sources", {f.background_source_select, f.foreground_source_select}, w[31:28]);
      chk("pat_flags", {f.pattern_fixed_fg, f.pattern_from_src}, {pt == 4'h8, pt == 4'h9});
      chk("mode", {f.clip_map_mode, f.drawing_mode_field, f.horizontal_direction_flag,
        f.vertical_direction_flag, f.major_axis_flag}, {w[7:4], w[2:0]});
      chk("reserved", f.reserved_code, k == POCR_OP_NONE || st[1:0] == 2'h3);
      @(posedge core_clk);
      mix <= 1'b1;
      ppel <= st[2];
      spel <= st[3];
      @(posedge core_clk);
      mix <= 1'b0;
      #1;
      efg = (pt == 4'h8) ? 1'b1 : (pt == 4'h9) ? st[3] : st[2];
      chk("mix_fg", mix_fg, efg);
      chk("mix_use_src", mix_use_src, efg ? fg[1] : bg[1]);
      if (!go) begin
        @(posedge core_clk);
        dsw <= 1'b1;
        @(posedge core_clk);
        dsw <= 1'b0;
        #1;
        chk("step_start", op_start, k inside {POCR_OP_STEP_READ, POCR_OP_STEP_WRITE});
      end
      wait_idle();
    end
    w = cmdw(2'h0, 2'h2, POCR_STEP_BLT, POCR_MAP_A, POCR_MAP_C, POCR_PAT_FIXED, 2'h1, 2'h2, 3'h5);
    for (int m = 0; m < 2; m++) begin
      bes <= m[0];
      for (int b = 0; b < 4; b++) begin
        ln = m ? 3 - b : b;
        wrt(5'h1F, 4'(1 << ln), 32'(w[8 * b +: 8]) << (8 * ln));
        chk("byte_start", op_start, b == 3);
      end
      chk("byte_kind", {f.op_kind, f.src_map, f.dst_map}, {POCR_OP_BLOCK, 8'h13});
      wait_idle();
    end
    bes <= 1'b0;
    lat <= 8'd40;
    wrt(5'h1F, 4'hF, w);
    wrt(5'h1F, 4'hF, {4'h0, POCR_STEP_IBLT, 24'h222000});
    chk("held", {op_start, f.op_kind, f.src_map, f.pat_map}, {1'b0, POCR_OP_BLOCK, 8'h18});
    wait_idle();
    chk("dropped", f.op_kind, POCR_OP_BLOCK);
    wrt(5'h1F, 4'h3, w);
    chk("half_low", op_start, 0);
    wrt(5'h1F, 4'hC, w);
    chk("half_high", op_start, 1);
    wait_idle();
    wrt(5'h1F, 4'hF, w | 32'h00000008);
    chk("unused_bit", {op_start, f.reserved_code}, 2'h3);
    wait_idle();
    end_sim();
  end
endmodule
`default_nettype wire
